// >>> verif/ubk_bus_model.sv
// model of the cpu, dma and external masters whose cycles the unit watches
`timescale 1ns/100ps
module ubk_bus_model (
  // clock
  input  wire logic          mclk,
  // observed bus cycle
  output logic               bus_valid = 1'b0,
  output logic [31:0]        bus_addr = 32'h0,
  output logic [31:0]        bus_data = 32'h0,
  output ubk_pkg::ubk_master_t bus_master = ubk_pkg::UBK_MST_CPU,
  output logic               bus_fetch = 1'b0,
  output logic               bus_write = 1'b0,
  output ubk_pkg::ubk_size_t bus_size = ubk_pkg::UBK_SZ_WORD
);
  import ubk_pkg::*;
  // one cycle per clock at most; calls chain back to back
  task automatic cycle(input logic [31:0] a, input logic [31:0] d, input ubk_master_t m,
      input logic f, input logic w, input ubk_size_t s);
    @(posedge mclk);
    bus_valid  <= 1'b1;
    bus_addr   <= a;
    bus_data   <= d;
    bus_master <= m;
    bus_fetch  <= f;
    bus_write  <= w;
    bus_size   <= s;
  endtask
  // a released bus shows the inverse of its last address, data and fetch; master, write and size hold
  task automatic idle();
    @(posedge mclk);
    bus_valid <= 1'b0;
    bus_addr  <= ~bus_addr;
    bus_data  <= ~bus_data;
    bus_fetch <= ~bus_fetch;
  endtask
endmodule

// >>> verif/ubk_top_props.sv
// concurrent checks on the ports of the user break unit
`timescale 1ns/100ps
`include "ubk_map.svh"
module ubk_top_props (
  // clock and power-on reset
  input wire logic                 MCLK,
  input wire logic                 RESET,
  // register port
  input wire logic [31:0]          REG_ADDR,
  input wire logic [15:0]          REG_WDATA,
  input wire logic                 REG_WR,
  input wire logic                 REG_RD,
  input wire logic [15:0]          REG_RDATA,
  // observed bus cycle
  input wire logic                 BUS_VALID,
  input wire logic [31:0]          BUS_ADDR,
  input wire logic [31:0]          BUS_DATA,
  input wire ubk_pkg::ubk_master_t BUS_MASTER,
  input wire logic                 BUS_FETCH,
  input wire logic                 BUS_WRITE,
  input wire ubk_pkg::ubk_size_t   BUS_SIZE,
  // break request
  input wire logic                 BREAK_REQ,
  input wire logic                 BREAK_POST,
  input wire logic [1:0]           BREAK_CHAN
);
  import ubk_pkg::*;
  logic [31:0] a_ref_reg;
  logic [31:0] a_msk_reg;
  logic [7:0]  cs_a_reg;
  logic [4:0]  ctrl_reg;
  logic        addr_ok;
  logic        mst_ok;
  logic        cyc_ok;
  logic        seq_on;
  logic        dual_on;
  // shadow of the channel A settings, rebuilt from the write traffic alone
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      a_ref_reg <= 32'h0;
      a_msk_reg <= 32'h0;
      cs_a_reg  <= 8'h0;
      ctrl_reg  <= 5'h0;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `UBK_A_ADDR_HI_ADR: a_ref_reg[31:16] <= REG_WDATA;
        `UBK_A_ADDR_LO_ADR: a_ref_reg[15:0] <= REG_WDATA;
        `UBK_A_MASK_HI_ADR: a_msk_reg[31:16] <= REG_WDATA;
        `UBK_A_MASK_LO_ADR: a_msk_reg[15:0] <= REG_WDATA;
        `UBK_A_CYC_SEL_ADR: cs_a_reg <= REG_WDATA[7:0];
        `UBK_CTRL_ADR:      ctrl_reg <= REG_WDATA[4:0];
        default: ;
      endcase
    end
  end
  assign addr_ok = ((BUS_ADDR ^ a_ref_reg) & ~a_msk_reg) == 32'h0;
  assign mst_ok  = (BUS_MASTER == UBK_MST_CPU && cs_a_reg[6]) ||
                   (BUS_MASTER == UBK_MST_DMA && cs_a_reg[7]) ||
                   (BUS_MASTER == UBK_MST_EXT && cs_a_reg[7] && ctrl_reg[`UBK_CTRL_EXT]);
  assign cyc_ok  = (BUS_FETCH ? cs_a_reg[4] : cs_a_reg[5]) &&
                   (BUS_WRITE ? cs_a_reg[3] : cs_a_reg[2]) &&
                   (cs_a_reg[1:0] == 2'h0 || cs_a_reg[1:0] == BUS_SIZE);
  assign seq_on  = ctrl_reg[`UBK_CTRL_SEQ];
  assign dual_on = ctrl_reg[`UBK_CTRL_DUAL];

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  property p_req_cause;
    BREAK_REQ |-> $past(BUS_VALID, 2);
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("break with no bus cycle");
  property p_a_fires;
    BUS_VALID && addr_ok && mst_ok && cyc_ok && !seq_on |-> ##2 BREAK_REQ && BREAK_CHAN[0];
  endproperty
  a_a_fires: assert property (p_a_fires) else $error("matching cycle gave no break");
  property p_a_addr;
    BREAK_CHAN[0] |-> $past(addr_ok, 2);
  endproperty
  a_a_addr: assert property (p_a_addr) else $error("channel A fired on other address");
  property p_a_mst;
    BREAK_CHAN[0] |-> $past(mst_ok, 2);
  endproperty
  a_a_mst: assert property (p_a_mst) else $error("channel A fired for wrong master");
  property p_a_cyc;
    BREAK_CHAN[0] |-> $past(cyc_ok, 2);
  endproperty
  a_a_cyc: assert property (p_a_cyc) else $error("channel A fired on wrong cycle kind");
  property p_post;
    BREAK_POST |-> BREAK_REQ && $past(BUS_FETCH, 2);
  endproperty
  a_post: assert property (p_post) else $error("after-execution flag on a data cycle");
  property p_legacy;
    BREAK_CHAN[1] |-> $past(dual_on, 2);
  endproperty
  a_legacy: assert property (p_legacy) else $error("channel B fired in legacy mode");
  property p_seq;
    BREAK_REQ && $past(seq_on, 2) && $past(dual_on, 2) |-> BREAK_CHAN == 2'b10;
  endproperty
  a_seq: assert property (p_seq) else $error("sequence break not from channel B");

  c_chan_a: cover property (BREAK_REQ && BREAK_CHAN == 2'b01);
  c_chan_b: cover property (BREAK_REQ && BREAK_CHAN == 2'b10);
  c_post: cover property (BREAK_POST);
endmodule

bind ubk_top ubk_top_props u_props (
  .MCLK(MCLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .BUS_VALID(BUS_VALID),
  .BUS_ADDR(BUS_ADDR), .BUS_DATA(BUS_DATA), .BUS_MASTER(BUS_MASTER), .BUS_FETCH(BUS_FETCH),
  .BUS_WRITE(BUS_WRITE), .BUS_SIZE(BUS_SIZE), .BREAK_REQ(BREAK_REQ),
  .BREAK_POST(BREAK_POST), .BREAK_CHAN(BREAK_CHAN));

// >>> verif/ubk_top_test.sv
// self-checking bench for the user break unit
`timescale 1ns/100ps
`include "ubk_map.svh"
module ubk_top_test;
  import ubk_pkg::*;
  logic        MCLK = 1'b0;
  logic        RESET = 1'b1;
  logic [31:0] REG_ADDR = 32'h0;
  logic [15:0] REG_WDATA = 16'h0;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic [15:0] REG_RDATA;
  logic        BUS_VALID;
  logic [31:0] BUS_ADDR;
  logic [31:0] BUS_DATA;
  ubk_master_t BUS_MASTER;
  logic        BUS_FETCH;
  logic        BUS_WRITE;
  ubk_size_t   BUS_SIZE;
  logic        BREAK_REQ;
  logic        BREAK_POST;
  logic [1:0]  BREAK_CHAN;
  int          fails = 0;
  int          n_checks = 0;
  logic [31:0] lfsr = 32'h15900429;
  logic [15:0] rd_q[$];
  logic [3:0]  brk_q[$];
  logic        rd_d = 1'b0;
  logic [1:0]  vld_d = 2'h0;
  logic [31:0] adr[17];
  logic [31:0] a_ref, a_msk, r, ba, dv;
  logic [7:0]  cs;
  logic [4:0]  ctl;
  logic [15:0] e;
  logic [1:0]  s;
  logic        h;

  always #5 MCLK = ~MCLK;

  ubk_bus_model bus (.mclk(MCLK), .bus_valid(BUS_VALID), .bus_addr(BUS_ADDR),
    .bus_data(BUS_DATA), .bus_master(BUS_MASTER), .bus_fetch(BUS_FETCH),
    .bus_write(BUS_WRITE), .bus_size(BUS_SIZE));
  ubk_top DUT (.MCLK(MCLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .BUS_VALID(BUS_VALID),
    .BUS_ADDR(BUS_ADDR), .BUS_DATA(BUS_DATA), .BUS_MASTER(BUS_MASTER), .BUS_FETCH(BUS_FETCH),
    .BUS_WRITE(BUS_WRITE), .BUS_SIZE(BUS_SIZE), .BREAK_REQ(BREAK_REQ),
    .BREAK_POST(BREAK_POST), .BREAK_CHAN(BREAK_CHAN));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // expected channel A verdict from the cycle select layout
  function automatic logic a_hit(input logic [31:0] a, input logic [1:0] m, input logic f,
      input logic w, input logic [1:0] sz);
    return ((a ^ a_ref) & ~a_msk) == 32'h0 && (f ? cs[4] : cs[5]) && (w ? cs[3] : cs[2]) &&
      (m == 2'h0 ? cs[6] : m == 2'h1 ? cs[7] : m == 2'h2 ? cs[7] & ctl[1] : 1'b0) &&
      (cs[1:0] == 2'h0 || cs[1:0] == sz);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge MCLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge MCLK);
    REG_WR    <= 1'b0;
  endtask
  // a 32-bit value goes as two 16-bit accesses, upper half first
  task automatic wr32(input logic [31:0] a, input logic [31:0] d);
    wr(a, d[31:16]);
    wr(a + 32'h2, d[15:0]);
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] x);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    rd_q.push_back(x);
    @(posedge MCLK);
    REG_RD   <= 1'b0;
  endtask
  task automatic bc(input logic [31:0] a, input logic [31:0] d, input logic [1:0] m,
      input logic f, input logic w, input logic [1:0] sz, input logic [3:0] x);
    bus.cycle(a, d, ubk_master_t'(m), f, w, ubk_size_t'(sz));
    brk_q.push_back(x);
  endtask
  task automatic finish_test();
    $display("checks %0d, errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // results appear one cycle after a read and two cycles after a bus cycle
  always @(posedge MCLK) begin
    if (rd_d)
      chk(REG_RDATA, rd_q.pop_front());
    if (vld_d[1])
      chk({BREAK_REQ, BREAK_POST, BREAK_CHAN}, brk_q.pop_front());
    else if (!RESET)
      chk({BREAK_REQ, BREAK_POST, BREAK_CHAN}, 16'h0);
    rd_d  <= REG_RD;
    vld_d <= {vld_d[0], BUS_VALID};
  end

  initial begin
    repeat (20000) @(posedge MCLK);
    fails++;
    finish_test();
  end

  initial begin
    adr = '{`UBK_A_ADDR_HI_ADR, `UBK_A_ADDR_LO_ADR, `UBK_A_MASK_HI_ADR, `UBK_A_MASK_LO_ADR,
      `UBK_A_CYC_SEL_ADR, `UBK_B_ADDR_HI_ADR, `UBK_B_ADDR_LO_ADR, `UBK_B_MASK_HI_ADR,
      `UBK_B_MASK_LO_ADR, `UBK_B_CYC_SEL_ADR, `UBK_B_DATA_HI_ADR, `UBK_B_DATA_LO_ADR,
      `UBK_B_DMASK_HI_ADR, `UBK_B_DMASK_LO_ADR, `UBK_CTRL_ADR, `UBK_STAT_ADR, 32'hFFFFFF4A};
    repeat (2) @(posedge MCLK);
    RESET <= 1'b0;
    for (int i = 0; i < 17; i++)
      rd(adr[i], 16'h0);
    // write and read back; unmapped word stays zero, status is left alone
    for (int i = 0; i < 17; i++) begin
      if (i == 15)
        continue;
      r = rnd();
      e = (i == 16) ? 16'h0 : (i == 4 || i == 9) ? {8'h0, r[7:0]} :
          (i == 14) ? {11'h0, r[4:0]} : r[15:0];
      wr(adr[i], r[15:0]);
      rd(adr[i], e);
    end
    // channel B would match any cpu or dma cycle, yet legacy mode keeps it silent
    wr32(`UBK_B_MASK_HI_ADR, 32'hFFFFFFFF);
    wr32(`UBK_B_DMASK_HI_ADR, 32'hFFFFFFFF);
    wr(`UBK_B_CYC_SEL_ADR, 16'h00FC);
    for (int n = 0; n < 40; n++) begin
      r = rnd();
      a_ref = rnd();
      a_msk = rnd() & rnd();
      cs = r[7:0];
      ctl = {2'b00, r[9:8], 1'b0};
      wr32(`UBK_A_ADDR_HI_ADR, a_ref);
      wr32(`UBK_A_MASK_HI_ADR, a_msk);
      wr(`UBK_A_CYC_SEL_ADR, {8'h0, cs});
      wr(`UBK_CTRL_ADR, {11'h0, ctl});
      for (int k = 0; k < 4; k++) begin
        r = rnd();
        ba = r[4] ? a_ref ^ (rnd() & a_msk) : rnd();
        s = (r[6:5] == 2'h0) ? 2'h1 : r[6:5];
        h = a_hit(ba, r[1:0], r[2], r[3], s);
        bc(ba, rnd(), r[1:0], r[2], r[3], s, {h, h & r[2] & ctl[2], 1'b0, h});
      end
      bus.idle();
    end
    // dual mode: only channel B weighs the data
    a_ref = rnd();
    dv = rnd();
    wr32(`UBK_A_ADDR_HI_ADR, a_ref);
    wr32(`UBK_A_MASK_HI_ADR, 32'h0);
    wr(`UBK_A_CYC_SEL_ADR, 16'h007C);
    wr32(`UBK_B_ADDR_HI_ADR, ~a_ref);
    wr32(`UBK_B_MASK_HI_ADR, 32'h0);
    wr32(`UBK_B_DATA_HI_ADR, dv);
    wr32(`UBK_B_DMASK_HI_ADR, 32'h0);
    wr(`UBK_B_CYC_SEL_ADR, 16'h007C);
    wr(`UBK_CTRL_ADR, 16'h0010);
    bc(~a_ref, dv, 2'h0, 1'b0, 1'b1, 2'h2, 4'b1010);
    bc(~a_ref, ~dv, 2'h0, 1'b0, 1'b1, 2'h2, 4'b0000);
    bc(a_ref, rnd(), 2'h0, 1'b0, 1'b1, 2'h2, 4'b1001);
    bus.idle();
    // sequence: B alone is ignored, A arms, the next B fires and disarms
    wr(`UBK_CTRL_ADR, 16'h0011);
    bc(~a_ref, dv, 2'h0, 1'b0, 1'b1, 2'h2, 4'b0000);
    bc(a_ref, dv, 2'h0, 1'b0, 1'b1, 2'h2, 4'b0000);
    bc(~a_ref, dv, 2'h0, 1'b0, 1'b1, 2'h2, 4'b1010);
    bc(~a_ref, dv, 2'h0, 1'b0, 1'b1, 2'h2, 4'b0000);
    bus.idle();
    // both channels have fired by now; the flags stay until cleared
    rd(`UBK_STAT_ADR, 16'h0003);
    wr(`UBK_STAT_ADR, 16'h0003);
    rd(`UBK_STAT_ADR, 16'h0000);
    repeat (4) @(posedge MCLK);
    finish_test();
  end
endmodule

// >>> verilog/ubk_chan.sv
// one break channel: address, attribute and optional data comparison
`timescale 1ns/100ps
`include "ubk_map.svh"
module ubk_chan #(
  parameter bit HAS_DATA = 1'b0
) (
  // observed cycle
  ubk_cyc_if.sink                    cyc,
  // settings
  input  wire logic [31:0]           addr_ref,
  input  wire logic [31:0]           addr_mask,
  input  wire logic [31:0]           data_ref,
  input  wire logic [31:0]           data_mask,
  input  wire logic [`UBK_CS_WIDTH-1:0] cyc_sel,
  input  wire logic                  ext_en,
  // result
  output logic                       hit
);
  import ubk_pkg::*;

  logic [1:0] mst_sel;
  logic [1:0] fet_sel;
  logic [1:0] dir_sel;
  logic [1:0] sz_sel;
  logic       addr_ok;
  logic       data_ok;
  logic       mst_ok;
  logic       fet_ok;
  logic       dir_ok;
  logic       sz_ok;

  assign mst_sel = cyc_sel[`UBK_CS_MST_HI:`UBK_CS_MST_LO];
  assign fet_sel = cyc_sel[`UBK_CS_FET_HI:`UBK_CS_FET_LO];
  assign dir_sel = cyc_sel[`UBK_CS_DIR_HI:`UBK_CS_DIR_LO];
  assign sz_sel  = cyc_sel[`UBK_CS_SIZE_HI:`UBK_CS_SIZE_LO];

  // a set mask bit drops that address bit from the compare
  assign addr_ok = ((cyc.addr ^ addr_ref) & ~addr_mask) == 32'h00000000;
  // the data compare exists only where the channel is built with it
  assign data_ok = !HAS_DATA || (((cyc.data ^ data_ref) & ~data_mask) == 32'h00000000);

  // dma cycles always count as peripheral, external masters only when enabled
  always_comb begin
    case (cyc.master)
      UBK_MST_CPU: mst_ok = mst_sel[0];
      UBK_MST_DMA: mst_ok = mst_sel[1];
      UBK_MST_EXT: mst_ok = mst_sel[1] && ext_en;
      default:     mst_ok = 1'b0;
    endcase
  end

  // a zero fetch or direction field selects nothing, so the channel stays silent; a zero size field takes any size
  assign fet_ok = cyc.fetch ? fet_sel[0] : fet_sel[1];
  assign dir_ok = cyc.write ? dir_sel[1] : dir_sel[0];
  assign sz_ok  = (sz_sel == UBK_SZ_NONE) || (sz_sel == cyc.size);

  assign hit = cyc.valid && addr_ok && data_ok && mst_ok && fet_ok && dir_ok && sz_ok;
endmodule

// >>> verilog/ubk_cyc_if.sv
// one observed bus cycle, passed from the top to the channel comparators
`timescale 1ns/100ps
interface ubk_cyc_if;
  logic                 valid;
  logic [31:0]          addr;
  logic [31:0]          data;
  ubk_pkg::ubk_master_t master;
  logic                 fetch;
  logic                 write;
  ubk_pkg::ubk_size_t   size;

  modport src  (output valid, addr, data, master, fetch, write, size);
  modport sink (input  valid, addr, data, master, fetch, write, size);
endinterface

// >>> verilog/ubk_map.svh
// register addresses, field positions and reset values of the user break unit
`ifndef UBK_MAP_SVH
`define UBK_MAP_SVH

// channel A
`define UBK_A_ADDR_HI_ADR   32'hFFFFFF40
`define UBK_A_ADDR_LO_ADR   32'hFFFFFF42
`define UBK_A_MASK_HI_ADR   32'hFFFFFF44
`define UBK_A_MASK_LO_ADR   32'hFFFFFF46
`define UBK_A_CYC_SEL_ADR   32'hFFFFFF48
// channel B
`define UBK_B_ADDR_HI_ADR   32'h0FFFFF60
`define UBK_B_ADDR_LO_ADR   32'h0FFFFF62
`define UBK_B_MASK_HI_ADR   32'h0FFFFF64
`define UBK_B_MASK_LO_ADR   32'h0FFFFF66
`define UBK_B_CYC_SEL_ADR   32'h0FFFFF68
`define UBK_B_DATA_HI_ADR   32'hFFFFFF70
`define UBK_B_DATA_LO_ADR   32'hFFFFFF72
`define UBK_B_DMASK_HI_ADR  32'hFFFFFF74
`define UBK_B_DMASK_LO_ADR  32'hFFFFFF76
// control and status
`define UBK_CTRL_ADR        32'hFFFFFF78
`define UBK_STAT_ADR        32'hFFFFFF7A

`define UBK_REG_RESET       16'h0000

// cycle select fields
`define UBK_CS_MST_HI       7
`define UBK_CS_MST_LO       6
`define UBK_CS_FET_HI       5
`define UBK_CS_FET_LO       4
`define UBK_CS_DIR_HI       3
`define UBK_CS_DIR_LO       2
`define UBK_CS_SIZE_HI      1
`define UBK_CS_SIZE_LO      0
`define UBK_CS_WIDTH        8

// control bits
`define UBK_CTRL_SEQ        0
`define UBK_CTRL_EXT        1
`define UBK_CTRL_A_POST     2
`define UBK_CTRL_B_POST     3
`define UBK_CTRL_DUAL       4
`define UBK_CTRL_WIDTH      5

// status bits
`define UBK_STAT_A          0
`define UBK_STAT_B          1

`endif

// >>> verilog/ubk_pkg.sv
// types shared by the user break unit modules
package ubk_pkg;

  // owner of an observed bus cycle
  typedef enum logic [1:0] {
    UBK_MST_CPU = 2'h0,
    UBK_MST_DMA = 2'h1,
    UBK_MST_EXT = 2'h2
  } ubk_master_t;

  // operand size of an observed bus cycle
  typedef enum logic [1:0] {
    UBK_SZ_NONE = 2'h0,
    UBK_SZ_BYTE = 2'h1,
    UBK_SZ_WORD = 2'h2,
    UBK_SZ_LONG = 2'h3
  } ubk_size_t;

  // sequential break tracking
  typedef enum {
    UBK_SEQ_IDLE,
    UBK_SEQ_ARMED
  } ubk_seq_t;

endpackage

// >>> verilog/ubk_top.sv
// user break unit: break registers, two channels and request sequencing
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`include "ubk_map.svh"
module ubk_top (
  // clock and power-on reset
  input  wire logic                 MCLK,
  input  wire logic                 RESET,
  // register port
  input  wire logic [31:0]          REG_ADDR,
  input  wire logic [15:0]          REG_WDATA,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  output logic      [15:0]          REG_RDATA,
  // observed bus cycle
  input  wire logic                 BUS_VALID,
  input  wire logic [31:0]          BUS_ADDR,
  input  wire logic [31:0]          BUS_DATA,
  input  wire ubk_pkg::ubk_master_t BUS_MASTER,
  input  wire logic                 BUS_FETCH,
  input  wire logic                 BUS_WRITE,
  input  wire ubk_pkg::ubk_size_t   BUS_SIZE,
  // break request to the exception logic
  output logic                      BREAK_REQ,
  output logic                      BREAK_POST,
  output logic      [1:0]           BREAK_CHAN
);
  import ubk_pkg::*;

  // software registers
  logic [15:0]                 a_addr_hi_reg;
  logic [15:0]                 a_addr_lo_reg;
  logic [15:0]                 a_mask_hi_reg;
  logic [15:0]                 a_mask_lo_reg;
  logic [`UBK_CS_WIDTH-1:0]    a_cyc_sel_reg;
  logic [15:0]                 b_addr_hi_reg;
  logic [15:0]                 b_addr_lo_reg;
  logic [15:0]                 b_mask_hi_reg;
  logic [15:0]                 b_mask_lo_reg;
  logic [`UBK_CS_WIDTH-1:0]    b_cyc_sel_reg;
  logic [15:0]                 b_data_hi_reg;
  logic [15:0]                 b_data_lo_reg;
  logic [15:0]                 b_dmask_hi_reg;
  logic [15:0]                 b_dmask_lo_reg;
  logic [`UBK_CTRL_WIDTH-1:0]  ctrl_reg;
  logic [1:0]                  stat_reg;
  logic [1:0]                  stat_next;
  logic [15:0]                 rdata_next;
  logic                        map_hit;

  // decoded control bits
  logic                        seq_en;
  logic                        ext_en;
  logic                        dual_en;

  // comparator results and pipeline
  logic                        hit_a;
  logic                        hit_b;
  logic                        hit_a_reg;
  logic                        hit_b_reg;
  logic                        fetch_reg;
  ubk_seq_t                    seq_reg;
  ubk_seq_t                    seq_next;
  logic                        fire_a;
  logic                        fire_b;
  logic                        req_next;
  logic                        post_next;
  logic [1:0]                  chan_next;

  ubk_cyc_if cyc ();

  assign seq_en  = ctrl_reg[`UBK_CTRL_SEQ];
  assign ext_en  = ctrl_reg[`UBK_CTRL_EXT];
  // zero after power-on, which leaves only channel A in use
  assign dual_en = ctrl_reg[`UBK_CTRL_DUAL];

  // ---------------------------------------------------------------
  // register writes; only the power-on reset clears them, so a
  // manual reset elsewhere in the chip leaves them as they were
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      a_addr_hi_reg <= `UBK_REG_RESET;
      a_addr_lo_reg <= `UBK_REG_RESET;
      a_mask_hi_reg <= `UBK_REG_RESET;
      a_mask_lo_reg <= `UBK_REG_RESET;
      a_cyc_sel_reg <= `UBK_CS_WIDTH'(`UBK_REG_RESET);
    end else if (REG_WR) begin
      case (REG_ADDR)
        `UBK_A_ADDR_HI_ADR: a_addr_hi_reg <= REG_WDATA;
        `UBK_A_ADDR_LO_ADR: a_addr_lo_reg <= REG_WDATA;
        `UBK_A_MASK_HI_ADR: a_mask_hi_reg <= REG_WDATA;
        `UBK_A_MASK_LO_ADR: a_mask_lo_reg <= REG_WDATA;
        `UBK_A_CYC_SEL_ADR: a_cyc_sel_reg <= REG_WDATA[`UBK_CS_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      b_addr_hi_reg  <= `UBK_REG_RESET;
      b_addr_lo_reg  <= `UBK_REG_RESET;
      b_mask_hi_reg  <= `UBK_REG_RESET;
      b_mask_lo_reg  <= `UBK_REG_RESET;
      b_cyc_sel_reg  <= `UBK_CS_WIDTH'(`UBK_REG_RESET);
      b_data_hi_reg  <= `UBK_REG_RESET;
      b_data_lo_reg  <= `UBK_REG_RESET;
      b_dmask_hi_reg <= `UBK_REG_RESET;
      b_dmask_lo_reg <= `UBK_REG_RESET;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `UBK_B_ADDR_HI_ADR:  b_addr_hi_reg  <= REG_WDATA;
        `UBK_B_ADDR_LO_ADR:  b_addr_lo_reg  <= REG_WDATA;
        `UBK_B_MASK_HI_ADR:  b_mask_hi_reg  <= REG_WDATA;
        `UBK_B_MASK_LO_ADR:  b_mask_lo_reg  <= REG_WDATA;
        `UBK_B_CYC_SEL_ADR:  b_cyc_sel_reg  <= REG_WDATA[`UBK_CS_WIDTH-1:0];
        `UBK_B_DATA_HI_ADR:  b_data_hi_reg  <= REG_WDATA;
        `UBK_B_DATA_LO_ADR:  b_data_lo_reg  <= REG_WDATA;
        `UBK_B_DMASK_HI_ADR: b_dmask_hi_reg <= REG_WDATA;
        `UBK_B_DMASK_LO_ADR: b_dmask_lo_reg <= REG_WDATA;
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ctrl_reg <= `UBK_CTRL_WIDTH'(`UBK_REG_RESET);
    end else if (REG_WR && REG_ADDR == `UBK_CTRL_ADR) begin
      ctrl_reg <= REG_WDATA[`UBK_CTRL_WIDTH-1:0];
    end
  end

  // sticky hit flags, cleared by writing one; a new hit in the
  // clearing cycle wins so no break is lost from the record
  always_comb begin
    stat_next = stat_reg;
    if (REG_WR && REG_ADDR == `UBK_STAT_ADR) begin
      stat_next = stat_reg & ~REG_WDATA[1:0];
    end
    if (fire_a) begin
      stat_next[`UBK_STAT_A] = 1'b1;
    end
    if (fire_b) begin
      stat_next[`UBK_STAT_B] = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      stat_reg <= 2'h0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // ---------------------------------------------------------------
  // register reads: data stands only in the cycle after the strobe;
  // reserved bits and unmapped addresses read as zero
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = 16'h0000;
    map_hit    = 1'b1;
    case (REG_ADDR)
      `UBK_A_ADDR_HI_ADR:  rdata_next = a_addr_hi_reg;
      `UBK_A_ADDR_LO_ADR:  rdata_next = a_addr_lo_reg;
      `UBK_A_MASK_HI_ADR:  rdata_next = a_mask_hi_reg;
      `UBK_A_MASK_LO_ADR:  rdata_next = a_mask_lo_reg;
      `UBK_A_CYC_SEL_ADR:  rdata_next = {8'h00, a_cyc_sel_reg};
      `UBK_B_ADDR_HI_ADR:  rdata_next = b_addr_hi_reg;
      `UBK_B_ADDR_LO_ADR:  rdata_next = b_addr_lo_reg;
      `UBK_B_MASK_HI_ADR:  rdata_next = b_mask_hi_reg;
      `UBK_B_MASK_LO_ADR:  rdata_next = b_mask_lo_reg;
      `UBK_B_CYC_SEL_ADR:  rdata_next = {8'h00, b_cyc_sel_reg};
      `UBK_B_DATA_HI_ADR:  rdata_next = b_data_hi_reg;
      `UBK_B_DATA_LO_ADR:  rdata_next = b_data_lo_reg;
      `UBK_B_DMASK_HI_ADR: rdata_next = b_dmask_hi_reg;
      `UBK_B_DMASK_LO_ADR: rdata_next = b_dmask_lo_reg;
      `UBK_CTRL_ADR:       rdata_next = {11'h000, ctrl_reg};
      `UBK_STAT_ADR:       rdata_next = {14'h0000, stat_reg};
      default:             map_hit    = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD && map_hit) begin
      REG_RDATA <= rdata_next;
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // observed cycle to both channels
  // ---------------------------------------------------------------
  assign cyc.valid  = BUS_VALID;
  assign cyc.addr   = BUS_ADDR;
  assign cyc.data   = BUS_DATA;
  assign cyc.master = BUS_MASTER;
  assign cyc.fetch  = BUS_FETCH;
  assign cyc.write  = BUS_WRITE;
  assign cyc.size   = BUS_SIZE;

  // channel A has no data compare, so its data inputs are fully masked
  ubk_chan #(
    .HAS_DATA (1'b0)
  ) u_chan_a (
    .cyc       (cyc),
    .addr_ref  ({a_addr_hi_reg, a_addr_lo_reg}),
    .addr_mask ({a_mask_hi_reg, a_mask_lo_reg}),
    .data_ref  (32'h00000000),
    .data_mask (32'hFFFFFFFF),
    .cyc_sel   (a_cyc_sel_reg),
    .ext_en    (ext_en),
    .hit       (hit_a)
  );

  ubk_chan #(
    .HAS_DATA (1'b1)
  ) u_chan_b (
    .cyc       (cyc),
    .addr_ref  ({b_addr_hi_reg, b_addr_lo_reg}),
    .addr_mask ({b_mask_hi_reg, b_mask_lo_reg}),
    .data_ref  ({b_data_hi_reg, b_data_lo_reg}),
    .data_mask ({b_dmask_hi_reg, b_dmask_lo_reg}),
    .cyc_sel   (b_cyc_sel_reg),
    .ext_en    (ext_en),
    .hit       (hit_b)
  );

  // ---------------------------------------------------------------
  // match stage: one evaluation per cycle, held for one clock so the
  // wide compare never sits in the same path as the request logic
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      hit_a_reg <= 1'b0;
      hit_b_reg <= 1'b0;
      fetch_reg <= 1'b0;
    end else begin
      hit_a_reg <= hit_a;
      hit_b_reg <= hit_b && dual_en;
      fetch_reg <= BUS_FETCH && BUS_VALID;
    end
  end

  // ---------------------------------------------------------------
  // channel combination
  // ---------------------------------------------------------------
  always_comb begin
    seq_next = seq_reg;
    fire_a   = 1'b0;
    fire_b   = 1'b0;
    if (dual_en && seq_en) begin
      // A only arms; a B hit in the same cycle as the arming A hit
      // does not count, since A has to come first
      case (seq_reg)
        UBK_SEQ_IDLE: begin
          if (hit_a_reg) begin
            seq_next = UBK_SEQ_ARMED;
          end
        end
        UBK_SEQ_ARMED: begin
          if (hit_b_reg) begin
            fire_b   = 1'b1;
            seq_next = UBK_SEQ_IDLE;
          end
        end
        default: seq_next = UBK_SEQ_IDLE;
      endcase
    end else begin
      fire_a   = hit_a_reg;
      fire_b   = hit_b_reg;
      seq_next = UBK_SEQ_IDLE;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      seq_reg <= UBK_SEQ_IDLE;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // post-execution break applies to fetch cycles only
  always_comb begin
    req_next  = fire_a || fire_b;
    chan_next = {fire_b, fire_a};
    post_next = fetch_reg && ((fire_a && ctrl_reg[`UBK_CTRL_A_POST]) ||
                              (fire_b && ctrl_reg[`UBK_CTRL_B_POST]));
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      BREAK_REQ  <= 1'b0;
      BREAK_POST <= 1'b0;
      BREAK_CHAN <= 2'h0;
    end else begin
      BREAK_REQ  <= req_next;
      BREAK_POST <= post_next;
      BREAK_CHAN <= chan_next;
    end
  end

endmodule
